// [sim/host_model.sv]
// host processor model: bus master that rings the doorbell and counts acks
`timescale 1ns/100ps
module host_model (
    input  wire logic        clock,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire logic        command_ack_irq_line
);
    int   ack_count;
    logic awaiting;
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        ack_count = 0;
        awaiting = 1'b0;
    end
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // request held until waitrequest seen low; a lost answer is left to the watchdog
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [31:0] direct_word(input logic [15:0] id);
        return {id, 14'h0000, radio_command_pkg::kind_direct};
    endfunction
    task automatic ring(input logic [31:0] w, input bit obey);
        logic [31:0] q;
        int          n;
        n = 0;
        while (obey && awaiting && n < 200) begin
            @(posedge clock);
            n++;
        end
        bus(1'b1, radio_command_pkg::doorbell_off, w, q);
        awaiting = 1'b1;
    endtask
    always @(posedge clock) begin
        if (command_ack_irq_line === 1'b1) begin
            ack_count <= ack_count + 1;
            awaiting <= 1'b0;
        end
    end
endmodule

// [sim/radio_command_status_report_tb.sv]
// self-checking bench for the command result and status block
`timescale 1ns/100ps
module radio_command_status_report_tb;
    logic        clock;
    logic        sys_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] command_doorbell_word;
    logic        result_post;
    logic [7:0]  result_code;
    logic [23:0] result_bytes;
    logic        result_is_op;
    logic        op_status_post;
    logic [15:0] op_status_code;
    logic        op_suspend;
    logic        op_suspend_capable;
    logic        command_ack_irq_line;
    logic        op_running;
    int          errors;
    int          n_compared;
    logic [31:0] q;
    logic [7:0]  codes [9] = '{8'h01, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89};
    logic [15:0] fins [7] = '{16'h0400, 16'h0403, 16'h0405, 16'h0800, 16'h0805, 16'h0807, 16'h080c};
    always #2.5 clock = ~clock;
    radio_command_status_report u_dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_strobe(), .command_doorbell_word(command_doorbell_word),
        .result_post(result_post), .result_code(result_code), .result_bytes(result_bytes),
        .result_is_op(result_is_op), .op_status_post(op_status_post), .op_status_code(op_status_code),
        .op_suspend(op_suspend), .op_suspend_capable(op_suspend_capable),
        .command_ack_irq_line(command_ack_irq_line),
        .op_running(op_running));
    host_model u_host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .command_ack_irq_line(command_ack_irq_line));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a);
        u_host.bus(1'b0, a, 32'h0000_0000, q);
    endtask
    // settle window after the ack shows any second pulse
    task automatic wait_ack(input int n0);
        int n;
        n = 0;
        while (u_host.ack_count == n0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        repeat (3) @(posedge clock);
        check(32'(u_host.ack_count - n0), 32'h0000_0001); // single ack
    endtask
    task automatic post(input logic [7:0] c, input logic [23:0] b, input logic op);
        int n0;
        n0 = u_host.ack_count;
        @(posedge clock);
        result_post <= 1'b1;
        result_code <= c;
        result_bytes <= b;
        result_is_op <= op;
        @(posedge clock);
        result_post <= 1'b0;
        wait_ack(n0);
    endtask
    task automatic status_post(input logic [15:0] c);
        @(posedge clock);
        op_status_post <= 1'b1;
        op_status_code <= c;
        @(posedge clock);
        op_status_post <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic start_op();
        u_host.ring(32'h0000_2000, 1'b1);
        post(8'h01, 24'h000000, 1'b1);
        check({31'h0, op_running}, 32'h0000_0001); // scheduled op
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(radio_command_pkg::result_off);
        check(q, radio_command_pkg::result_rst); // reads pending
        rd(4'hc);
        check(q, 32'h0000_0000); // unmapped reads zero
        u_host.bus(1'b1, radio_command_pkg::result_off, 32'hffff_ffff, q);
        rd(radio_command_pkg::result_off);
        check(q, 32'h0000_0000); // read-only result
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0000_0000); // starts not-started
    endtask
    task automatic t_codes();
        for (int i = 0; i < 9; i++) begin
            u_host.ring(u_host.direct_word(16'h0400 + 16'(i)), 1'b1);
            @(negedge clock);
            check(command_doorbell_word, u_host.direct_word(16'h0400 + 16'(i))); // word kept
            rd(radio_command_pkg::result_off);
            check(q, 32'h0000_0000); // cleared on ring
            post(codes[i], 24'habcd00 + 24'(i), 1'b0);
            rd(radio_command_pkg::result_off);
            check(q, {24'habcd00 + 24'(i), codes[i]});
            check({31'h0, q[7]}, {31'h0, codes[i] >= 8'h80}); // error bit
        end
    endtask
    task automatic t_bad_ptr();
        int n0;
        n0 = u_host.ack_count;
        u_host.ring(32'h0000_0102, 1'b1);
        wait_ack(n0);
        rd(radio_command_pkg::result_off);
        check(q, 32'h0000_0081); // self-posted
    endtask
    task automatic t_ops();
        start_op();
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0001_0001); // waiting code
        u_host.ring(32'h0000_3000, 1'b1);
        post(8'h01, 24'h000000, 1'b1);
        rd(radio_command_pkg::result_off);
        check(q, 32'h0000_0086); // overlap rejected
        status_post(16'h0002);
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0001_0002); // first op runs on
        for (int i = 0; i < 7; i++) begin
            if (i > 0)
                start_op();
            status_post(fins[i]);
            check({31'h0, op_running}, 32'h0000_0000); // finished
            rd(radio_command_pkg::op_status_off);
            check(q, {16'h0000, fins[i]}); // code kept
        end
    endtask
    task automatic t_suspend();
        start_op();
        @(posedge clock);
        op_suspend <= 1'b1;
        @(posedge clock);
        op_suspend <= 1'b0;
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0001_0001); // no suspend without capability
        @(posedge clock);
        op_suspend_capable <= 1'b1;
        op_suspend <= 1'b1;
        @(posedge clock);
        op_suspend <= 1'b0;
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0003_0001); // capable operation suspends
        op_suspend_capable <= 1'b0;
        status_post(16'h0806);
        check({31'h0, op_running}, 32'h0000_0000); // unknown code ends operation
        rd(radio_command_pkg::op_status_off);
        check(q, 32'h0000_0803); // stored as parameter error
    endtask
    task automatic t_refused();
        u_host.ring(32'h0000_4000, 1'b1);
        u_host.ring(32'h0000_5000, 1'b0);
        @(negedge clock);
        check(command_doorbell_word, 32'h0000_4000); // early ring dropped
        post(8'h01, 24'h000001, 1'b0);
        u_host.ring(32'h0000_6000, 1'b1);
        post(8'h55, 24'h000002, 1'b0);
        rd(radio_command_pkg::result_off);
        check(q, 32'h0000_0287); // unknown code becomes 0x87
    endtask
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        result_post = 1'b0;
        result_code = 8'h00;
        result_bytes = 24'h000000;
        result_is_op = 1'b0;
        op_status_post = 1'b0;
        op_status_code = 16'h0000;
        op_suspend = 1'b0;
        op_suspend_capable = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_codes();
        t_bad_ptr();
        t_ops();
        t_suspend();
        t_refused();
        final_report();
    end
    initial begin
        #(5 * 20000);
        errors++;
        final_report();
    end
endmodule

// [verilog/radio_command_pkg.sv]
// constants for the command doorbell and result reporting block
package radio_command_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [3:0] doorbell_off  = 4'h0;
    localparam logic [3:0] result_off    = 4'h4;
    localparam logic [3:0] op_status_off = 4'h8;
    localparam logic [31:0] result_rst    = 32'h0000_0000;
    localparam logic [15:0] op_status_rst = 16'h0000;
    // ----------------------------------------
    // doorbell word layout
    // ----------------------------------------
    localparam int          kind_lsb    = 0;
    localparam logic [1:0]  kind_ptr    = 2'h0;
    localparam logic [1:0]  kind_direct = 2'h1;
    // ----------------------------------------
    // result byte codes
    // ----------------------------------------
    localparam int         err_bit              = 7;
    localparam logic [7:0] pending_result       = 8'h00;
    localparam logic [7:0] done_result          = 8'h01;
    localparam logic [7:0] bad_pointer_result   = 8'h81;
    localparam logic [7:0] unknown_id_result    = 8'h82;
    localparam logic [7:0] unknown_dir_result   = 8'h83;
    localparam logic [7:0] wrong_context_result = 8'h85;
    localparam logic [7:0] overlap_reject_result = 8'h86;
    localparam logic [7:0] bad_parameter_result = 8'h87;
    localparam logic [7:0] queue_state_result   = 8'h88;
    localparam logic [7:0] entry_in_use_result  = 8'h89;
    // ----------------------------------------
    // operation status field codes
    // ----------------------------------------
    localparam logic [15:0] st_idle       = 16'h0000;
    localparam logic [15:0] st_pending    = 16'h0001;
    localparam logic [15:0] st_active     = 16'h0002;
    localparam logic [15:0] st_skipped    = 16'h0003;
    localparam logic [15:0] st_done_first = 16'h0400;
    localparam logic [15:0] st_done_last  = 16'h0405;
    localparam logic [15:0] st_err_first  = 16'h0800;
    localparam logic [15:0] st_err_cmdid  = 16'h0805;
    localparam logic [15:0] st_err_par    = 16'h0803;
    localparam logic [15:0] st_no_setup   = 16'h0807;
    localparam logic [15:0] st_err_last   = 16'h080c;
    // status register flag positions
    localparam int op_active_bit = 16;
    localparam int suspended_bit = 17;
    localparam int awaiting_bit  = 18;
endpackage

// [verilog/radio_command_status_report.sv]
// command doorbell, result register and operation status reporting
`timescale 1ns/100ps
// Contract
// - every command ends in result write plus ack
// - result posted at completion or at scheduling
// - result is code byte plus 24 return bits
// - bit 7 set exactly for error results
// - doorbell write clears result to pending (a write while awaiting_reg is set is dropped and clears nothing)
// - 0x01 for done or accepted operation
// - 0x81 for invalid structure pointer
// - 0x82 for unknown structure command identifier
// - 0x83 for unknown or non-direct direct command
// - 0x85 for command in wrong context
// - 0x86 rejects operation while one runs
// - 0x87 submission errors, later errors in status
// - 0x88 for queue operation in wrong state
// - 0x89 for busy data entry
// - unfinished status codes 0x0000 to 0x0003
// - normal finish codes 0x0400 to 0x0405
// - error finish codes 0x0800 to 0x0805
// - codes 0x0807 to 0x0809 for setup faults
// - codes 0x080a to 0x080c for modem faults
// - suspended state only for capable operations
module radio_command_status_report (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             cmd_strobe,
    output logic      [31:0] command_doorbell_word,
    input  wire logic        result_post,
    input  wire logic [7:0]  result_code,
    input  wire logic [23:0] result_bytes,
    input  wire logic        result_is_op,
    input  wire logic        op_status_post,
    input  wire logic [15:0] op_status_code,
    input  wire logic        op_suspend,
    input  wire logic        op_suspend_capable,
    output logic             command_ack_irq_line,
    output logic             op_running
);
    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // legal result codes
    function automatic logic result_known(input logic [7:0] c);
        result_known = (c == radio_command_pkg::done_result) ||
                       (c == radio_command_pkg::bad_pointer_result) ||
                       (c == radio_command_pkg::unknown_id_result) ||
                       (c == radio_command_pkg::unknown_dir_result) ||
                       (c == radio_command_pkg::wrong_context_result) ||
                       (c == radio_command_pkg::overlap_reject_result) ||
                       (c == radio_command_pkg::bad_parameter_result) ||
                       (c == radio_command_pkg::queue_state_result) ||
                       (c == radio_command_pkg::entry_in_use_result);
    endfunction

    function automatic logic status_finished(input logic [15:0] s);
        status_finished = (s >= radio_command_pkg::st_done_first && s <= radio_command_pkg::st_done_last) ||
                          (s >= radio_command_pkg::st_err_first && s <= radio_command_pkg::st_err_cmdid) ||
                          (s >= radio_command_pkg::st_no_setup && s <= radio_command_pkg::st_err_last);
    endfunction

    function automatic logic status_known(input logic [15:0] s);
        status_known = (s <= radio_command_pkg::st_skipped) || status_finished(s);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic        bus_ack_reg;
    logic [31:0] readdata_reg;
    logic [31:0] doorbell_reg;
    logic        strobe_reg;
    logic        bad_ptr_reg;
    logic        awaiting_reg;
    logic [31:0] result_reg;
    logic [31:0] result_next;
    logic        ack_reg;
    logic        op_active_reg;
    logic        suspended_reg;
    logic [15:0] op_status_reg;
    logic [15:0] op_status_next;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // every access answers one cycle after it is raised
    wire bus_req      = avs_read | avs_write;
    wire bus_take     = bus_req & bus_ack_reg;
    wire doorbell_hit = avs_write & bus_take & (avs_address == radio_command_pkg::doorbell_off);
    wire [1:0] kind   = avs_writedata[radio_command_pkg::kind_lsb +: 2];
    // pending command blocks
    // a doorbell write before the ack is dropped so results never mix
    wire doorbell_ok  = doorbell_hit & ~awaiting_reg;
    wire kind_bad     = (kind != radio_command_pkg::kind_ptr) && (kind != radio_command_pkg::kind_direct);
    wire [31:0] op_status_word = {13'h0000, awaiting_reg, suspended_reg, op_active_reg, op_status_reg};
    wire [31:0] read_mux =
        (avs_address == radio_command_pkg::doorbell_off)  ? doorbell_reg :
        (avs_address == radio_command_pkg::result_off)    ? result_reg :
        (avs_address == radio_command_pkg::op_status_off) ? op_status_word : 32'h0000_0000;

    // ----------------------------------------
    // result posting
    // ----------------------------------------
    wire post_ok = result_post & awaiting_reg & ~bad_ptr_reg & ~doorbell_ok;
    wire overlap = result_is_op & op_active_reg & (result_code == radio_command_pkg::done_result);
    wire [7:0] code_fixed = overlap ? radio_command_pkg::overlap_reject_result :
                            result_known(result_code) ? result_code : radio_command_pkg::bad_parameter_result;
    wire write_result = post_ok | bad_ptr_reg;
    wire op_accept    = post_ok & result_is_op & (code_fixed == radio_command_pkg::done_result);
    // unknown codes are stored as a parameter error, which also ends the operation
    wire [15:0] status_fixed = status_known(op_status_code) ? op_status_code : radio_command_pkg::st_err_par;
    wire op_finish    = op_status_post & op_active_reg & status_finished(status_fixed);

    always_comb begin
        result_next = result_reg;
        if (doorbell_ok) begin
            result_next = radio_command_pkg::result_rst;
        end else if (bad_ptr_reg) begin
            result_next = {24'h000000, radio_command_pkg::bad_pointer_result};
        end else if (post_ok) begin
            result_next = {result_bytes, code_fixed};
        end
    end

    always_comb begin
        op_status_next = op_status_reg;
        if (op_status_post & op_active_reg) begin
            op_status_next = status_fixed;
        end else if (op_accept) begin
            op_status_next = radio_command_pkg::st_pending;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_ack_reg  <= 1'b0;
            readdata_reg <= 32'h0000_0000;
        end else begin
            bus_ack_reg  <= bus_req & ~bus_ack_reg;
            readdata_reg <= read_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            doorbell_reg <= 32'h0000_0000;
            strobe_reg   <= 1'b0;
            bad_ptr_reg  <= 1'b0;
            awaiting_reg <= 1'b0;
            result_reg   <= radio_command_pkg::result_rst;
            ack_reg      <= 1'b0;
        end else begin
            doorbell_reg <= doorbell_ok ? avs_writedata : doorbell_reg;
            strobe_reg   <= doorbell_ok & ~kind_bad;
            bad_ptr_reg  <= doorbell_ok & kind_bad;
            awaiting_reg <= doorbell_ok | (awaiting_reg & ~write_result);
            result_reg   <= result_next;
            ack_reg      <= write_result;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            op_active_reg <= 1'b0;
            suspended_reg <= 1'b0;
            op_status_reg <= radio_command_pkg::op_status_rst;
        end else begin
            op_active_reg <= op_accept | (op_active_reg & ~op_finish);
            suspended_reg <= (suspended_reg | (op_suspend & op_suspend_capable & op_active_reg)) &
                             ~op_finish & ~op_accept;
            op_status_reg <= op_status_next;
        end
    end

    assign avs_waitrequest       = bus_req & ~bus_ack_reg;
    assign avs_readdata          = readdata_reg;
    assign cmd_strobe            = strobe_reg;
    assign command_doorbell_word = doorbell_reg;
    assign command_ack_irq_line  = ack_reg;
    assign op_running            = op_active_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    doorbell_clear_a: assert property (doorbell_ok |=> result_reg == 32'h0000_0000)
        else $error("result not cleared by doorbell");
    bad_ptr_post_a: assert property (doorbell_ok && kind_bad |-> ##2 result_reg[7:0] == 8'h81 && ack_reg)
        else $error("bad pointer not reported");
    ack_follows_a: assert property (post_ok |=> command_ack_irq_line)
        else $error("ack missing after result");
    ack_single_a: assert property (ack_reg |=> !ack_reg [*1] ##0 !awaiting_reg)
        else $error("second ack or still waiting");
    err_bit_a: assert property (ack_reg |-> result_reg[7] == (result_reg[7:0] != 8'h01))
        else $error("error bit inconsistent");
    overlap_keep_a: assert property (post_ok && overlap |=> result_reg[7:0] == 8'h86 && op_active_reg)
        else $error("overlap not rejected");
    busy_drop_a: assert property (doorbell_hit && awaiting_reg |=> $stable(doorbell_reg) && !cmd_strobe)
        else $error("doorbell taken while waiting");
    status_legal_a: assert property (op_status_post && op_active_reg |=> status_known(op_status_reg))
        else $error("illegal status stored");
    suspend_gate_a: assert property ($rose(suspended_reg) |-> $past(op_suspend_capable))
        else $error("suspend without capability");
    op_start_a: assert property (op_accept |=> op_running && op_status_reg == 16'h0001)
        else $error("operation not started");

    direct_cmd_c: cover property (doorbell_ok && kind == 2'h1 ##1 cmd_strobe ##[1:20] ack_reg);
    op_run_c: cover property (op_accept ##[1:40] op_finish);
    overlap_c: cover property (post_ok && overlap);
    bad_ptr_c: cover property (bad_ptr_reg ##1 ack_reg);
endmodule
